// [rtl/spi_slave_pkg.sv]
// Package: constants for the SPI slave port
package spi_slave_pkg;
  localparam int WORD_BITS = 16;
  localparam int CNT_W = 5;
  localparam int MASTER_BIT_POS = 0;
  localparam int PHASE_BIT_POS = 16;
  localparam int POLARITY_BIT_POS = 17;
  localparam int PRESCALE_LSB = 8;
  localparam int PRESCALE_MSB = 15;
  localparam logic [31:0] GLOBAL_CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] FORMAT_RESET = 32'h0000_0000;
  localparam int MIN_SCLK_PERIOD_NS = 25;
  localparam int CLK_PERIOD_NS = 10;
  // Least cycles per serial period, rounded up
  localparam int MIN_SCLK_CYCLES = (MIN_SCLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_LAST = 5'h0f;
endpackage

// [rtl/spi_sync_if.sv]
// Interface: synchronised link levels from the sampler to the port
`timescale 1ns/100ps
`default_nettype none
interface spi_sync_if;
  logic sclk;
  logic cs_active;
  logic sdi;
  modport src (output sclk, output cs_active, output sdi);
  modport dst (input sclk, input cs_active, input sdi);
endinterface
`default_nettype wire

// [rtl/spi_link_sync.sv]
// Module: two-flop synchroniser for the link pins
`timescale 1ns/100ps
`default_nettype none
module spi_link_sync
  import spi_slave_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclk_pin,
  input wire logic cs_b_pin,
  input wire logic sdi_pin,
  spi_sync_if.src out
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
  } sync_s;
  sync_s st_r;
  sync_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = {sclk_pin, ~cs_b_pin, sdi_pin};
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign out.sclk = st_r.s2[2];
  assign out.cs_active = st_r.s2[1];
  assign out.sdi = st_r.s2[0];
endmodule
`default_nettype wire

// [rtl/spi_slave_port.sv]
// Top: SPI slave port on the subsystem clock
// What this block does
// - Slave mode while master bit is clear
// - Phase bit selects capture edge
// - Polarity bit selects active edges
// - Sample falling when polarity equals phase
// - Launch after rising if polarity zero
`timescale 1ns/100ps
`default_nettype none
module spi_slave_port
  import spi_slave_pkg::*;
#(
  parameter int WIDTH = WORD_BITS
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [31:0] GLOBAL_CONTROL,
  input wire logic [31:0] FORMAT,
  input wire logic SERIAL_CLOCK_IN,
  input wire logic CHIP_SELECT_B,
  input wire logic SERIAL_DATA_IN,
  input wire logic [WIDTH-1:0] TX_WORD,
  output logic SERIAL_DATA_OUT,
  output logic SERIAL_DATA_OUT_EN,
  output logic TX_TAKEN,
  output logic [WIDTH-1:0] RX_WORD,
  output logic RX_VALID,
  output logic SLAVE_ACTIVE
);
  // ====================================================
  // Link sampling
  spi_sync_if sync ();

  spi_link_sync u_sync (
    .clk(CLK),
    .rst_b(RST_B),
    .sclk_pin(SERIAL_CLOCK_IN),
    .cs_b_pin(CHIP_SELECT_B),
    .sdi_pin(SERIAL_DATA_IN),
    .out(sync)
  );

  // ====================================================
  // State
  typedef enum logic [1:0] {IDLE, FRAME} phase_e;
  typedef struct packed {
    phase_e st;
    logic sclk_d;
    logic [CNT_W-1:0] cnt;
    logic [WIDTH-1:0] rx_sh;
    logic [WIDTH-1:0] tx_sh;
    logic sdo;
    logic sdo_en;
    logic taken;
    logic [WIDTH-1:0] rx_word;
    logic rx_valid;
    logic active;
  } port_s;
  port_s st_r;
  port_s st_nxt;

  logic slave_mode;
  logic cpha;
  logic cpol;
  logic rise;
  logic fall;
  logic sample_edge;
  logic launch_edge;
  logic [WIDTH-1:0] rx_next;

  always_comb begin
    slave_mode = ~GLOBAL_CONTROL[MASTER_BIT_POS];
    cpha = FORMAT[PHASE_BIT_POS];
    cpol = FORMAT[POLARITY_BIT_POS];
    rise = sync.sclk & ~st_r.sclk_d;
    fall = ~sync.sclk & st_r.sclk_d;
    sample_edge = (cpol == cpha) ? fall : rise;
    launch_edge = cpol ? fall : rise;
    rx_next = {st_r.rx_sh[WIDTH-2:0], sync.sdi};

    st_nxt = st_r;
    st_nxt.sclk_d = sync.sclk;
    st_nxt.taken = 1'b0;
    st_nxt.rx_valid = 1'b0;
    st_nxt.active = slave_mode & sync.cs_active;
    case (st_r.st)
      IDLE: begin
        // Partial words dropped while deselected
        st_nxt.cnt = CNT_ZERO;
        st_nxt.rx_sh = '0;
        st_nxt.sdo_en = 1'b0;
        if (slave_mode && sync.cs_active) begin
          st_nxt.st = FRAME;
          st_nxt.tx_sh = TX_WORD;
          st_nxt.sdo = TX_WORD[WIDTH-1];
          st_nxt.sdo_en = 1'b1;
          st_nxt.taken = 1'b1;
        end
      end
      FRAME: begin
        if (!slave_mode || !sync.cs_active) begin
          st_nxt.st = IDLE;
          st_nxt.cnt = CNT_ZERO;
          st_nxt.sdo_en = 1'b0;
        end else begin
          if (sample_edge) begin
            st_nxt.rx_sh = rx_next;
            if (st_r.cnt == CNT_LAST) begin
              st_nxt.rx_word = rx_next;
              st_nxt.rx_valid = 1'b1;
              st_nxt.cnt = CNT_ZERO;
            end else begin
              st_nxt.cnt = st_r.cnt + 5'h01;
            end
          end
          // Phase 0 has MSB out before first edge; phase 1 shifts on first edge
          if (launch_edge && (cpha || st_r.cnt != CNT_ZERO || sample_edge)) begin
            st_nxt.tx_sh = {st_r.tx_sh[WIDTH-2:0], 1'b0};
            st_nxt.sdo = cpha ? st_r.tx_sh[WIDTH-1] : st_r.tx_sh[WIDTH-2];
          end
        end
      end
      default: begin
        st_nxt.st = IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign SERIAL_DATA_OUT = st_r.sdo;
  assign SERIAL_DATA_OUT_EN = st_r.sdo_en;
  assign TX_TAKEN = st_r.taken;
  assign RX_WORD = st_r.rx_word;
  assign RX_VALID = st_r.rx_valid;
  assign SLAVE_ACTIVE = st_r.active;
endmodule
`default_nettype wire

// [verif/spi_slave_port_checker.sv]
// Checker for the SPI slave port
`timescale 1ns/100ps
`default_nettype none
module spi_slave_port_checker (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [31:0] GLOBAL_CONTROL,
  input wire logic CHIP_SELECT_B,
  input wire logic SERIAL_DATA_OUT_EN,
  input wire logic TX_TAKEN,
  input wire logic RX_VALID,
  input wire logic SLAVE_ACTIVE
);
  // ====
  // Properties
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  AST_MASTER_OFF: assert property (GLOBAL_CONTROL[0] [*4] |-> !SLAVE_ACTIVE)
    else $error("active in master mode");
  AST_SELECT: assert property ((!CHIP_SELECT_B && !GLOBAL_CONTROL[0]) [*5] |-> SLAVE_ACTIVE)
    else $error("select missed");
  AST_EN_MODE: assert property (SERIAL_DATA_OUT_EN |-> !$past(GLOBAL_CONTROL[0]))
    else $error("output driven in master mode");
  AST_TAKEN: assert property (TX_TAKEN |-> SLAVE_ACTIVE && SERIAL_DATA_OUT_EN)
    else $error("word taken while idle");
  AST_IDLE: assert property (CHIP_SELECT_B [*4] |-> !SLAVE_ACTIVE)
    else $error("active while deselected");
  AST_RX_GAP: assert property (RX_VALID |=> !RX_VALID [*8])
    else $error("words too close");
  AST_SYNC: assert property ($fell(CHIP_SELECT_B) |-> !SLAVE_ACTIVE [*2])
    else $error("select used unsynchronised");
  cover property (RX_VALID);
  cover property (TX_TAKEN);
  cover property ($fell(SLAVE_ACTIVE));
endmodule
bind spi_slave_port spi_slave_port_checker chk (.*);
`default_nettype wire

// [verif/spi_host_model.sv]
// Host master model for the serial link
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  output logic SCLK,
  output logic CS_B,
  output logic MOSI,
  input wire logic MISO
);
  // ====
  // Framing
  initial {SCLK, CS_B, MOSI} = 3'h2;
  task automatic xfer(input logic [15:0] tx, input int n, input logic cpol,
                      input logic cpha, output logic [15:0] rx);
    rx = 16'h0;
    SCLK = cpol;
    // Idle level settles before select, no stray edge
    #160 CS_B = 1'b0;
    #320;
    // Data moves mid half-period, never with a clock edge
    for (int i = 15; i > 15 - n; i--) begin
      #40;
      if (cpha) MOSI = tx[i];
      #40 SCLK = !cpol;
      #40;
      if (!cpha) MOSI = tx[i];
      #40 rx[i] = MISO;
      SCLK = cpol;
    end
    #80 CS_B = 1'b1;
    MOSI = !MOSI;
  endtask
endmodule
`default_nettype wire

// [verif/spi_slave_port_tb.sv]
// Self-checking bench for the SPI slave port
`timescale 1ns/100ps
`default_nettype none
module spi_slave_port_tb;
  import spi_slave_pkg::*;
  // ====
  // Harness
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [31:0] gctl = 32'h0;
  logic [31:0] fmt = 32'h0;
  logic [15:0] txw = 16'h0;
  logic [15:0] rxw, last_rx;
  logic sclk, cs_b, mosi, sdo, oe, act, taken, rxv;
  int failures = 0;
  int num_checks = 0;
  int nrx = 0;
  int noe = 0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    nrx <= nrx + (rxv === 1'b1);
    noe <= noe + (oe === 1'b1);
    if (rxv === 1'b1) last_rx <= rxw;
  end
  spi_slave_port uut (.CLK(clk), .RST_B(rst_b), .GLOBAL_CONTROL(gctl), .FORMAT(fmt),
    .SERIAL_CLOCK_IN(sclk), .CHIP_SELECT_B(cs_b), .SERIAL_DATA_IN(mosi), .TX_WORD(txw),
    .SERIAL_DATA_OUT(sdo), .SERIAL_DATA_OUT_EN(oe), .TX_TAKEN(taken), .RX_WORD(rxw),
    .RX_VALID(rxv), .SLAVE_ACTIVE(act));
  spi_host_model host (.SCLK(sclk), .CS_B(cs_b), .MOSI(mosi), .MISO(oe ? sdo : !sdo));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ====
  // Scenarios
  task automatic t_modes;
    logic [15:0] r;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk) fmt <= {14'h0, m[1:0], 16'h0};
      txw <= 16'ha5c3 ^ 16'(m);
      host.xfer(16'h3c96 + 16'(m), 16, m[1], m[0], r);
      repeat (8) @(posedge clk);
      cmp(last_rx, 16'h3c96 + 16'(m));
      cmp(r, 16'ha5c3 ^ 16'(m));
    end
  endtask
  task automatic t_abort;
    logic [15:0] r;
    int n;
    n = nrx;
    host.xfer(16'hffff, 5, 1'b1, 1'b1, r);
    host.xfer(16'h0001, 16, 1'b1, 1'b1, r);
    repeat (8) @(posedge clk);
    cmp(last_rx, 16'h0001);
    cmp(16'(nrx - n), 16'h1);
  endtask
  task automatic t_master;
    logic [15:0] r;
    int n;
    int e;
    @(posedge clk) gctl <= 32'h1;
    n = nrx;
    e = noe;
    host.xfer(16'h1234, 16, 1'b1, 1'b1, r);
    repeat (8) @(posedge clk);
    cmp(16'(nrx - n), 16'h0);
    cmp(16'(noe - e), 16'h0);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    cmp({12'h0, oe, act, taken, rxv}, 16'h0);
    t_modes();
    t_abort();
    t_master();
    end_sim();
  end
  // Frames take about 20 us in all
  initial begin
    #200000;
    failures++;
    end_sim();
  end
endmodule
`default_nettype wire
